//--- design/power_gate_ctrl.sv
`timescale 1ns/10ps
module power_gate_ctrl #(
   parameter int NUM_CPU      = 4,
   parameter int RAM_SELECTS  = 8,
   parameter bit SCAN_DEFAULT = 1'b0,
   parameter bit SNOOP_DEFAULT = 1'b0,
   parameter bit DOUBLE_RATE  = 1'b0
) (
   input  wire logic                   pclk,               // continuous clock
   input  wire logic                   presetn,            // async reset, active low
   input  wire logic                   psel,               // apb select
   input  wire logic                   penable,            // apb access phase
   input  wire logic                   pwrite,             // apb direction
   input  wire logic [11:0]            paddr,              // apb byte address
   input  wire logic [31:0]            pwdata,             // apb write data
   output logic      [31:0]            prdata,             // apb read data
   output logic                        pready,             // apb ready
   output logic                        pslverr,            // apb error
   input  wire logic [NUM_CPU-1:0]     bus_busy,           // accesses outstanding
   input  wire logic [NUM_CPU-1:0]     irq_pending,        // pending interrupt
   input  wire logic [NUM_CPU-1:0]     debug_halt,         // debug entry request
   output logic      [NUM_CPU-1:0]     safe_to_gate,       // clock may stop
   output logic      [NUM_CPU-1:0]     interrupt_waiting,  // restart clock
   output logic      [NUM_CPU-1:0]     debug_sleep_vector, // debug-unit sleep
   output logic      [NUM_CPU-1:0]     gate_core_clock,    // stop gated core clk
   output logic      [NUM_CPU-1:0]     gate_double_clock,  // stop gated double clk
   output logic                        snoop_clock_active, // snooping on free clk
   input  wire logic                   test_enable,        // scan test mode
   input  wire logic                   scan_enable,        // scan shift
   input  wire logic                   scan_test_reset,    // scan reset, unused
   input  wire logic [RAM_SELECTS-1:0] ram_select_in,      // ram selects from core
   output logic      [RAM_SELECTS-1:0] ram_select_out      // ram selects to rams
);
   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   logic                  setup_phase;
   logic                  access_phase;
   logic                  mapped;
   logic [NUM_CPU-1:0]    sleep_request;
   logic                  scan_support;
   logic                  snoop_enable;
   logic                  next_scan_support;
   logic                  next_snoop_enable;
   logic [31:0]           next_prdata;
   logic [NUM_CPU-1:0]    next_gate_core;
   logic [NUM_CPU-1:0]    next_gate_double;
   logic                  next_snoop_active;

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == power_gate_pkg::OFF_SLEEP_REQ) ||
                  (addr == power_gate_pkg::OFF_STATUS)    ||
                  (addr == power_gate_pkg::OFF_DEBUG)     ||
                  (addr == power_gate_pkg::OFF_CONFIG);
   endfunction

   function automatic logic is_write(input logic [11:0] addr,
                                     input logic [11:0] target,
                                     input logic        sel,
                                     input logic        en,
                                     input logic        wr);
      is_write = sel & en & wr & (addr == target);
   endfunction

   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign mapped       = is_mapped(paddr);
   // zero wait states: read data is captured in the setup cycle
   assign pready       = 1'b1;
   assign pslverr      = access_phase & ~mapped;

   always_comb begin
      sleep_request = {NUM_CPU{1'b0}};
      if (is_write(paddr, power_gate_pkg::OFF_SLEEP_REQ, psel, penable, pwrite)) begin
         sleep_request = pwdata[NUM_CPU-1:0];
      end
      next_scan_support = scan_support;
      next_snoop_enable = snoop_enable;
      if (is_write(paddr, power_gate_pkg::OFF_CONFIG, psel, penable, pwrite)) begin
         next_scan_support = pwdata[power_gate_pkg::CFG_SCAN_BIT];
         next_snoop_enable = pwdata[power_gate_pkg::CFG_SNOOP_BIT];
      end
      next_prdata = prdata;
      if (setup_phase) begin
         next_prdata = power_gate_pkg::ZERO_WORD;
         if (paddr == power_gate_pkg::OFF_STATUS) begin
            next_prdata[NUM_CPU-1:0] = safe_to_gate;
            next_prdata[power_gate_pkg::HI_FIELD +: NUM_CPU] = interrupt_waiting;
         end else if (paddr == power_gate_pkg::OFF_DEBUG) begin
            next_prdata[NUM_CPU-1:0] = debug_sleep_vector;
         end else if (paddr == power_gate_pkg::OFF_CONFIG) begin
            next_prdata[power_gate_pkg::CFG_SCAN_BIT]  = scan_support;
            next_prdata[power_gate_pkg::CFG_SNOOP_BIT] = snoop_enable;
         end
      end
   end

   // ----------------------------------------------------------------
   // clock gate requests
   // ----------------------------------------------------------------
   always_comb begin
      // double-rate build stops only the double clock; base clocks run free
      next_gate_core    = DOUBLE_RATE ? {NUM_CPU{1'b0}} : safe_to_gate;
      next_gate_double  = DOUBLE_RATE ? safe_to_gate : {NUM_CPU{1'b0}};
      // snoop logic lives on pclk, which never stops, so coherence holds
      next_snoop_active = snoop_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata             <= power_gate_pkg::ZERO_WORD;
         scan_support       <= SCAN_DEFAULT;
         snoop_enable       <= SNOOP_DEFAULT;
         gate_core_clock    <= {NUM_CPU{1'b0}};
         gate_double_clock  <= {NUM_CPU{1'b0}};
         snoop_clock_active <= SNOOP_DEFAULT;
      end else begin
         prdata             <= next_prdata;
         scan_support       <= next_scan_support;
         snoop_enable       <= next_snoop_enable;
         gate_core_clock    <= next_gate_core;
         gate_double_clock  <= next_gate_double;
         snoop_clock_active <= next_snoop_active;
      end
   end

   // ----------------------------------------------------------------
   // per-cpu power-down trackers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CPU; gi++) begin : cpu
         sleep_tracker #(
            .NODE (gi)
         ) tracker (
            .pclk              (pclk),
            .presetn           (presetn),
            .sleep_request     (sleep_request[gi]),
            .bus_busy          (bus_busy[gi]),
            .irq_pending       (irq_pending[gi]),
            .debug_halt        (debug_halt[gi]),
            .safe_to_gate      (safe_to_gate[gi]),
            .interrupt_waiting (interrupt_waiting[gi]),
            .debug_sleep       (debug_sleep_vector[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // scan protection
   // ----------------------------------------------------------------
   // combinational on purpose: a register here would itself sit in the chain
   // scan_test_reset stays unread, every flop resets from presetn only
   logic shift_block;
   assign shift_block    = scan_support & test_enable & scan_enable;
   assign ram_select_out = shift_block ? {RAM_SELECTS{1'b0}} : ram_select_in;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_sleep_write(int idx);
      psel && penable && pwrite && paddr == power_gate_pkg::OFF_SLEEP_REQ && pwdata[idx];
   endsequence

   sequence s_busy_cpu0;
      bus_busy[0] && !irq_pending[0] && !debug_halt[0];
   endsequence

   a_scan_ram_off: assert property (@(posedge pclk) disable iff (!presetn)
      (scan_support && test_enable && scan_enable) |-> (ram_select_out == '0))
      else $error("ram select active during scan shift");

   a_scan_pass: assert property (@(posedge pclk) disable iff (!presetn)
      !(scan_support && test_enable && scan_enable) |-> (ram_select_out == ram_select_in))
      else $error("ram select blocked outside scan shift");

   a_write_drain: assert property (@(posedge pclk) disable iff (!presetn)
      (s_sleep_write(0) ##0 s_busy_cpu0 ##0 !safe_to_gate[0])
      |=> s_busy_cpu0 |=> !safe_to_gate[0])
      else $error("gate raised before accesses drained");

   a_gate_route: assert property (@(posedge pclk) disable iff (!presetn)
      safe_to_gate[0] |=> (DOUBLE_RATE ? gate_double_clock[0] && !gate_core_clock[0]
                                       : gate_core_clock[0] && !gate_double_clock[0]))
      else $error("gate request on wrong clock");

   a_snoop_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (snoop_enable && |safe_to_gate) ##1 snoop_enable |-> snoop_clock_active)
      else $error("snooping dropped while gated");

   sequence s_status_setup;
      psel && !penable && paddr == power_gate_pkg::OFF_STATUS;
   endsequence

   sequence s_access;
      psel && penable;
   endsequence

   // status is frozen at setup, so it must match the lanes one edge earlier
   a_status_safe: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_setup ##1 s_access |-> (prdata[NUM_CPU-1:0] == $past(safe_to_gate)))
      else $error("status read does not show drained lanes");

   a_status_wake: assert property (@(posedge pclk) disable iff (!presetn)
      s_status_setup ##1 s_access
      |-> (prdata[power_gate_pkg::HI_FIELD +: NUM_CPU] == $past(interrupt_waiting)))
      else $error("status read does not show waking lanes");

   // ----------------------------------------------------------------
   // per-lane checks, every cpu rather than cpu 0 alone
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < NUM_CPU; gi++) begin : lane_chk
         a_lane_route: assert property (@(posedge pclk) disable iff (!presetn)
            safe_to_gate[gi] |=> (gate_core_clock[gi] == !DOUBLE_RATE) &&
                                 (gate_double_clock[gi] == DOUBLE_RATE))
            else $error("lane gate request on wrong clock");

         a_lane_sleep: assert property (@(posedge pclk) disable iff (!presetn)
            debug_sleep_vector[gi] |-> safe_to_gate[gi])
            else $error("debug sleep bit set on undrained lane");
      end
   endgenerate
endmodule

//--- design/power_gate_pkg.sv
// Behaviour
// - safe-to-gate only after bus accesses drain
// - pending interrupt wakes core, flags interrupt-waiting
// - debug sleep vector per cpu, interrupt-aware
// - snooping stays on continuous clock while gated
// - nodes above zero sleep straight after reset
// - gated clock input; double-rate gates only double
// - scan shift disables all ram selects
// - scan test reset input is ignored
package power_gate_pkg;
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 32;
   localparam int          MAX_CPU       = 16;
   localparam int          HI_FIELD      = 16;
   // register byte offsets
   localparam logic [11:0] OFF_SLEEP_REQ = 12'h000;
   localparam logic [11:0] OFF_STATUS    = 12'h004;
   localparam logic [11:0] OFF_DEBUG     = 12'h008;
   localparam logic [11:0] OFF_CONFIG    = 12'h00c;
   // config fields
   localparam int          CFG_SCAN_BIT  = 0;
   localparam int          CFG_SNOOP_BIT = 1;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

   typedef enum logic [1:0] {
      RUN,
      DRAIN,
      IDLE
   } sleep_state_type;
endpackage

//--- design/sleep_tracker.sv
`timescale 1ns/10ps
module sleep_tracker #(
   parameter int NODE = 0
) (
   input  wire logic pclk,              // continuous clock
   input  wire logic presetn,           // async reset, active low
   input  wire logic sleep_request,     // one-cycle power-down request
   input  wire logic bus_busy,          // cache/mmu access outstanding
   input  wire logic irq_pending,       // interrupt pending for this cpu
   input  wire logic debug_halt,        // debug unit pulls cpu to debug
   output logic      safe_to_gate,      // clock may be stopped
   output logic      interrupt_waiting, // wake indication
   output logic      debug_sleep        // sleep bit including wake causes
);
   // ----------------------------------------------------------------
   // power-down state
   // ----------------------------------------------------------------
   localparam power_gate_pkg::sleep_state_type BOOT_STATE =
      (NODE == 0) ? power_gate_pkg::RUN : power_gate_pkg::DRAIN;

   power_gate_pkg::sleep_state_type state;
   power_gate_pkg::sleep_state_type next_state;
   logic                            next_safe;
   logic                            next_waiting;
   logic                            next_debug_sleep;
   logic                            wake;
   logic                            boot_seen;

   always_comb begin
      wake       = irq_pending | debug_halt;
      next_state = state;
      case (state)
         power_gate_pkg::RUN: begin
            if (sleep_request & ~wake) begin
               next_state = power_gate_pkg::DRAIN;
            end
         end
         power_gate_pkg::DRAIN: begin
            if (wake) begin
               next_state = power_gate_pkg::RUN;
            end else if (~bus_busy) begin
               next_state = power_gate_pkg::IDLE;
            end
         end
         power_gate_pkg::IDLE: begin
            if (wake) begin
               next_state = power_gate_pkg::RUN;
            end
         end
         default: begin
            next_state = power_gate_pkg::RUN;
         end
      endcase
      next_safe        = (next_state == power_gate_pkg::IDLE);
      next_waiting     = irq_pending & (state != power_gate_pkg::RUN);
      // already folds in wake causes, so the gate needs no wake input of its own
      next_debug_sleep = next_safe & ~wake;
   end

   // nodes above zero boot straight into power-down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state             <= BOOT_STATE;
         safe_to_gate      <= 1'b0;
         interrupt_waiting <= 1'b0;
         debug_sleep       <= 1'b0;
         boot_seen         <= 1'b0;
      end else begin
         state             <= next_state;
         safe_to_gate      <= next_safe;
         interrupt_waiting <= next_waiting;
         debug_sleep       <= next_debug_sleep;
         boot_seen         <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_gate_no_busy: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(safe_to_gate) |-> !$past(bus_busy))
      else $error("gate raised while access outstanding");

   a_drain_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state == power_gate_pkg::DRAIN && bus_busy && !wake) |=> !safe_to_gate)
      else $error("gate raised during drain");

   a_wake_on_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (state != power_gate_pkg::RUN && irq_pending)
      |=> (state == power_gate_pkg::RUN && interrupt_waiting && !safe_to_gate))
      else $error("pending interrupt did not wake core");

   a_sleep_vec_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_pending || debug_halt) |=> !debug_sleep)
      else $error("debug sleep bit ignores wake cause");

   a_node_boot: assert property (@(posedge pclk) disable iff (!presetn)
      (!boot_seen && NODE != 0) |-> (state != power_gate_pkg::RUN))
      else $error("secondary node did not boot into power-down");
endmodule

//--- sim/clock_gate_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// external clock gate, one lane per cpu
// ----------------------------------------
module clock_gate_model #(
   parameter int N = 4
) (
   input  wire logic         pclk,      // continuous clock
   input  wire logic         presetn,   // reset, active low
   input  wire logic [N-1:0] sleep_vec, // debug-unit sleep vector
   input  wire logic [N-1:0] wake,      // interrupt waiting
   output logic      [N-1:0] clk_en     // gated clock enable
);
   logic [N-1:0] stage_rise;
   logic [N-1:0] stage_fall;

   // sleep vector already carries the wake causes; wake is or-ed in as belt and braces
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stage_rise <= '0;
      else          stage_rise <= sleep_vec & ~wake;
   end

   // the falling-edge stage keeps the gate from cutting a high phase short
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) stage_fall <= '0;
      else          stage_fall <= stage_rise;
   end

   assign clk_en = ~stage_fall | {N{~presetn}};
endmodule

//--- sim/processor_clock_gating_tb_top.sv
`timescale 1ns/10ps
module processor_clock_gating_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        snoop_clock_active, test_enable, scan_enable, scan_test_reset;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  bus_busy, irq_pending, debug_halt, safe_to_gate, interrupt_waiting;
   logic [3:0]  debug_sleep_vector, gate_core_clock, gate_double_clock, clk_en;
   logic [7:0]  ram_select_in, ram_select_out;
   logic        err;
   logic [3:0]  dbl_core_gate, dbl_double_gate;
   int          n_fail, n_checks;

   power_gate_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_busy(bus_busy), .irq_pending(irq_pending),
      .debug_halt(debug_halt), .safe_to_gate(safe_to_gate),
      .interrupt_waiting(interrupt_waiting), .debug_sleep_vector(debug_sleep_vector),
      .gate_core_clock(gate_core_clock), .gate_double_clock(gate_double_clock),
      .snoop_clock_active(snoop_clock_active), .test_enable(test_enable),
      .scan_enable(scan_enable), .scan_test_reset(scan_test_reset),
      .ram_select_in(ram_select_in), .ram_select_out(ram_select_out));

   clock_gate_model #(.N(4)) gate (.pclk(pclk), .presetn(presetn),
      .sleep_vec(debug_sleep_vector), .wake(interrupt_waiting), .clk_en(clk_en));

   // second build with the double-rate clock split, same stimulus
   power_gate_ctrl #(.DOUBLE_RATE(1'b1)) dut_double (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .bus_busy(bus_busy), .irq_pending(irq_pending),
      .debug_halt(debug_halt), .safe_to_gate(), .interrupt_waiting(),
      .debug_sleep_vector(), .gate_core_clock(dbl_core_gate),
      .gate_double_clock(dbl_double_gate), .snoop_clock_active(),
      .test_enable(test_enable), .scan_enable(scan_enable),
      .scan_test_reset(scan_test_reset), .ram_select_in(ram_select_in), .ram_select_out());

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // pready is sampled at the edge; no wait-state count is assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // clock, watchdog
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial begin
      repeat (3000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [11:0] addr_t[5];
      logic [31:0] exp_t[5];
      int          i;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; bus_busy = 4'h1; irq_pending = 4'h0;
      debug_halt = 4'h0; test_enable = 1'b0; scan_enable = 1'b0; scan_test_reset = 1'b0;
      ram_select_in = 8'ha5;
      repeat (3) @(posedge pclk);
      #1 chk("safe_in_reset", 32'h0000_0000, {28'h0, safe_to_gate});
      chk("clk_en_in_reset", 32'h0000_000f, {28'h0, clk_en});
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1 chk("safe_after_reset", 32'h0000_000e, {28'h0, safe_to_gate});
      chk("dsv_after_reset", 32'h0000_000e, {28'h0, debug_sleep_vector});
      @(posedge pclk);
      #1 chk("gate_core", 32'h0000_000e, {28'h0, gate_core_clock});
      chk("gate_double", 32'h0000_0000, {28'h0, gate_double_clock});
      chk("dbl_gate_core", 32'h0000_0000, {28'h0, dbl_core_gate});
      chk("dbl_gate_double", 32'h0000_000e, {28'h0, dbl_double_gate});
      #10 chk("model_en", 32'h0000_0001, {28'h0, clk_en});
      addr_t = '{power_gate_pkg::OFF_STATUS, power_gate_pkg::OFF_DEBUG,
                 power_gate_pkg::OFF_CONFIG, power_gate_pkg::OFF_SLEEP_REQ, 12'h010};
      exp_t  = '{32'h0000_000e, 32'h0000_000e, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
      for (i = 0; i < 5; i++) begin
         apb(1'b0, addr_t[i], 32'h0000_0000);
         chk("read_data", exp_t[i], q);
         chk("read_err", {31'h0, i == 4}, {31'h0, err});
      end
      apb(1'b1, 12'h010, 32'hffff_ffff);
      chk("write_err", 32'h0000_0001, {31'h0, err});
      apb(1'b1, power_gate_pkg::OFF_SLEEP_REQ, 32'h0000_0001);
      repeat (5) @(posedge pclk);
      #1 chk("safe_while_busy", 32'h0000_000e, {28'h0, safe_to_gate});
      @(posedge pclk);
      bus_busy <= 4'h0;
      @(posedge pclk);
      #1 chk("safe_drained", 32'h0000_000f, {28'h0, safe_to_gate});
      @(posedge pclk);
      #1 chk("gate_core_0", 32'h0000_000f, {28'h0, gate_core_clock});
      @(posedge pclk);
      irq_pending <= 4'h1;
      @(posedge pclk);
      #1 chk("wake_flag", 32'h0000_0001, {28'h0, interrupt_waiting});
      chk("wake_safe", 32'h0000_000e, {28'h0, safe_to_gate});
      chk("wake_dsv", 32'h0000_000e, {28'h0, debug_sleep_vector});
      @(posedge pclk);
      irq_pending <= 4'h0;
      debug_halt  <= 4'h2;
      @(posedge pclk);
      #1 chk("debug_dsv", 32'h0000_000c, {28'h0, debug_sleep_vector});
      @(posedge pclk);
      #11 chk("model_restart", 32'h0000_0003, {28'h0, clk_en});
      apb(1'b1, power_gate_pkg::OFF_CONFIG, 32'h0000_0003);
      @(posedge pclk);
      #1 chk("snoop_on", 32'h0000_0001, {31'h0, snoop_clock_active});
      apb(1'b0, power_gate_pkg::OFF_CONFIG, 32'h0000_0000);
      chk("config_read", 32'h0000_0003, q);
      for (i = 0; i < 8; i++) begin
         @(posedge pclk);
         test_enable     <= i[0];
         scan_enable     <= i[1];
         scan_test_reset <= i[2];
         #1 chk("ram_select", (i[1:0] == 2'b11) ? 32'h0000_0000 : 32'h0000_00a5,
                {24'h0, ram_select_out});
      end
      apb(1'b1, power_gate_pkg::OFF_CONFIG, 32'h0000_0000);
      #1 chk("ram_select_no_scan", 32'h0000_00a5, {24'h0, ram_select_out});
      print_verdict();
   end
endmodule
